// ---- shared/pat_pkg.sv ----
// Constants shared by the three-channel 8-bit timer.
// Assumes one system clock feeds both the divide-by-12 and the fast prescaler taps.
package pat_pkg;
  localparam int NCH  = 3;
  localparam int AW   = 10;
  localparam int DW   = 32;

  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] CTRL_IDX [NCH] = '{8'hB4, 8'hC1, 8'hC4};
  localparam logic [7:0] CNT_IDX  [NCH] = '{8'hB5, 8'hC2, 8'hC5};
  localparam logic [7:0] DATA_IDX [NCH] = '{8'hB6, 8'hC3, 8'hC6};

  localparam int BIT_EN  = 7;
  localparam int BIT_CLR = 6;
  localparam int BIT_FS  = 3;
  localparam int BIT_OE  = 1;
  localparam int BIT_MD  = 0;

  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [7:0] CNT_RST      = 8'h00;
  localparam logic [7:0] CNT_TOP      = 8'hFF;
  localparam logic [7:0] CTRL_RW_MASK = 8'hBB;

  localparam int         NDIV       = 7;
  localparam int         DIV_W      = 18;
  localparam logic [3:0] PRE12_LAST = 4'hB;
  localparam int         DIV_EXP [NDIV] = '{0, 4, 5, 7, 10, 14, 18};
  localparam logic [2:0] FS_EVENT   = 3'h7;

  typedef enum logic {
    PAT_AUTO_RELOAD = 1'b0,
    PAT_PWM         = 1'b1
  } pat_mode_t;
endpackage

// ---- shared/pat_tick_if.sv ----
// Counting-clock ticks from the prescaler to the timer channels.
// Assumes every tick is a one-cycle pulse in the mclk domain.
`timescale 1ns/1ns
interface pat_tick_if;
  logic [pat_pkg::NDIV-1:0] div_tick;
  logic [pat_pkg::NCH-1:0]  evt_tick;
  modport source (output div_tick, output evt_tick);
  modport sink (input div_tick, input evt_tick);
endinterface

// ---- design/pat_prescaler.sv ----
// Shared prescaler: divide-by-12, fast power-of-two taps and event-pin falling edges.
// Assumes the event pins are already synchronous to mclk.
`timescale 1ns/1ns
module pat_prescaler (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic [pat_pkg::NCH-1:0] event_input_pin,
  pat_tick_if.source                   tk
);
  import pat_pkg::*;

  logic [3:0]       pre12_q;
  logic [DIV_W-1:0] div_q;
  logic [NCH-1:0]   evt_q;
  logic [NDIV-1:0]  tick_d;
  logic [NDIV-1:0]  tick_q;
  logic [NCH-1:0]   evt_tick_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre12_q <= 4'h0;
      div_q   <= '0;
    end else begin
      pre12_q <= (pre12_q == PRE12_LAST) ? 4'h0 : pre12_q + 4'h1;
      div_q   <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign tick_d[0] = (pre12_q == PRE12_LAST);
  for (genvar g = 1; g < NDIV; g++) begin : g_tap
    localparam int E = DIV_EXP[g];
    assign tick_d[g] = &div_q[E-1:0];
  end

  // The counters step on the falling edge of the event pin.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q      <= '0;
      evt_tick_q <= '0;
      tick_q     <= '0;
    end else begin
      evt_q      <= event_input_pin;
      evt_tick_q <= evt_q & ~event_input_pin;
      tick_q     <= tick_d;
    end
  end

  assign tk.div_tick = tick_q;
  assign tk.evt_tick = evt_tick_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_DIV12_PERIOD: assert property (tick_q[0] |-> ##12 tick_q[0])
    else $error("Divide-by-12 tick period is not 12 cycles.");
  AST_FAST16_GAP: assert property (tick_q[1] |=> !tick_q[1] [*8] ##8 tick_q[1])
    else $error("Fast divide-by-16 tick period is not 16 cycles.");
endmodule

// ---- design/pat_channel.sv ----
// One 8-bit timer channel: counter, comparator and wave output.
// Assumes clear has priority over counting and ticks are one-cycle pulses.
`timescale 1ns/1ns
module pat_channel #(
  parameter int CH = 0
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  pat_tick_if.sink                tk,
  input  wire logic               enable,
  input  pat_pkg::pat_mode_t      wave_mode_select,
  input  wire logic [2:0]         count_clock_select,
  input  wire logic [7:0]         compare_value,
  input  wire logic               count_clear,
  output logic      [7:0]         count_value,
  output logic                    step,
  output logic                    match,
  output logic                    wave
);
  import pat_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] nxt;
  logic [7:0] last;
  logic [7:0] src;
  logic       tick;
  logic       wrap;
  logic       step_w;
  logic       arm_q;
  logic       match_q;
  logic       wave_q;

  always_comb begin
    src    = {tk.evt_tick[CH], tk.div_tick};
    tick   = src[count_clock_select];
    last   = compare_value - 8'h01;
    wrap   = (wave_mode_select == PAT_PWM) ? (cnt_q == CNT_TOP) : (cnt_q == last);
    step_w = enable && tick && !arm_q && !count_clear;
    nxt    = wrap ? CNT_RST : cnt_q + 8'h01;
  end

  // The first tick after start only arms the channel, so the first period runs one tick long.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 1'b1;
    end else if (count_clear || !enable) begin
      arm_q <= 1'b1;
    end else if (tick) begin
      arm_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_RST;
    end else if (count_clear) begin
      cnt_q <= CNT_RST;
    end else if (step_w) begin
      cnt_q <= nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= step_w && wrap && (wave_mode_select == PAT_AUTO_RELOAD);
    end
  end

  // In auto-reload mode the wave toggles on each match for a half-duty square output.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wave_q <= 1'b0;
    end else if (step_w) begin
      if (wave_mode_select == PAT_PWM) begin
        if (nxt == CNT_RST) begin
          wave_q <= (compare_value != DATA_RST);
        end else if (nxt == compare_value) begin
          wave_q <= 1'b0;
        end
      end else if (wrap) begin
        wave_q <= ~wave_q;
      end
    end
  end

  assign count_value = cnt_q;
  assign step        = step_w;
  assign match       = match_q;
  assign wave        = wave_q;
endmodule

// ---- design/pat_timer.sv ----
// Three-channel 8-bit auto-reload and pulse-width timer with an APB register slave.
// Assumes a zero-wait APB master; pins are synchronous to mclk.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module pat_timer (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [pat_pkg::AW-1:0]  paddr,
  input  wire logic [pat_pkg::DW-1:0]  pwdata,
  output logic      [pat_pkg::DW-1:0]  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [pat_pkg::NCH-1:0] event_input_pin,
  input  wire logic [pat_pkg::NCH-1:0] gpio_port_out,
  output logic      [pat_pkg::NCH-1:0] pulse_width_pin,
  output logic      [pat_pkg::NCH-1:0] timer_irq
);
  import pat_pkg::*;

  logic [7:0]    ctrl_q [NCH];
  logic [7:0]    data_q [NCH];
  logic [7:0]    cnt_w  [NCH];
  logic [NCH-1:0] clr_q;
  logic [NCH-1:0] step_w;
  logic [NCH-1:0] match_w;
  logic [NCH-1:0] wave_w;
  logic [NCH-1:0] pin_q;
  logic [NCH-1:0] irq_q;
  logic [NCH-1:0] hit_ctrl;
  logic [NCH-1:0] hit_cnt;
  logic [NCH-1:0] hit_data;
  logic [DW-1:0]  prdata_q;
  logic [7:0]     rd_d;
  logic           pready_q;
  logic           pslverr_q;
  logic           hit_any;
  logic           setup;
  logic           wr_en;

  pat_tick_if tk ();

  pat_prescaler u_pre (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .event_input_pin (event_input_pin),
    .tk              (tk)
  );

  // Address decode and read mux; reserved and clear bits always read as zero.
  always_comb begin
    hit_any = 1'b0;
    rd_d    = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      hit_ctrl[i] = (paddr == {CTRL_IDX[i], 2'b00});
      hit_cnt[i]  = (paddr == {CNT_IDX[i], 2'b00});
      hit_data[i] = (paddr == {DATA_IDX[i], 2'b00});
      hit_any     = hit_any | hit_ctrl[i] | hit_cnt[i] | hit_data[i];
      if (hit_ctrl[i]) begin
        rd_d = ctrl_q[i] & CTRL_RW_MASK;
      end
      if (hit_cnt[i]) begin
        rd_d = cnt_w[i];
      end
      if (hit_data[i]) begin
        rd_d = data_q[i];
      end
    end
  end

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite;

  // Answer is prepared in the setup cycle so every access completes with no wait state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit_any;
      prdata_q  <= (setup && !pwrite && hit_any) ? {24'h000000, rd_d} : '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= CTRL_RST;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_en && hit_ctrl[i]) begin
          ctrl_q[i] <= pwdata[7:0] & CTRL_RW_MASK;
        end
      end
    end
  end

  // The clear bit is never stored: a write of one gives a single-cycle pulse.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clr_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        clr_q[i] <= wr_en && hit_ctrl[i] && pwdata[BIT_CLR];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        data_q[i] <= DATA_RST;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_en && hit_data[i]) begin
          data_q[i] <= pwdata[7:0];
        end
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    pat_channel #(
      .CH (g)
    ) u_ch (
      .mclk               (mclk),
      .rst_n              (rst_n),
      .tk                 (tk),
      .enable             (ctrl_q[g][BIT_EN]),
      .wave_mode_select   (pat_mode_t'(ctrl_q[g][BIT_MD])),
      .count_clock_select (ctrl_q[g][BIT_FS +: 3]),
      .compare_value      (data_q[g]),
      .count_clear        (clr_q[g]),
      .count_value        (cnt_w[g]),
      .step               (step_w[g]),
      .match              (match_w[g]),
      .wave               (wave_w[g])
    );
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= '0;
      irq_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        pin_q[i] <= ctrl_q[i][BIT_OE] ? wave_w[i] : gpio_port_out[i];
        irq_q[i] <= match_w[i];
      end
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign pulse_width_pin = pin_q;
  assign timer_irq       = irq_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_CLR_READS_ZERO: assert property (pready_q |-> !prdata_q[BIT_CLR])
    else $error("Clear bit read back as one.");

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    AST_MATCH_WRAPS: assert property (match_w[g] |-> cnt_w[g] == CNT_RST)
      else $error("Match seen with counter not at zero.");

    AST_MATCH_IRQ: assert property (match_w[g] |=> timer_irq[g])
      else $error("Match did not raise the interrupt request.");

    AST_MATCH_MODE: assert property (match_w[g] |-> !$past(ctrl_q[g][BIT_MD]))
      else $error("Match raised outside auto-reload mode.");

    AST_AR_PERIOD: assert property (
      disable iff (!rst_n || wr_en)
      (match_w[g] && ctrl_q[g][BIT_EN] && !ctrl_q[g][BIT_MD]
       && ctrl_q[g][BIT_FS +: 3] == 3'h0 && data_q[g] == 8'h02)
      |=> !match_w[g] [*8] ##16 match_w[g])
      else $error("Auto-reload period differs from data times tick period.");

    AST_AR_FIRST: assert property (
      disable iff (!rst_n || wr_en)
      (clr_q[g] && ctrl_q[g][BIT_EN] && !ctrl_q[g][BIT_MD]
       && ctrl_q[g][BIT_FS +: 3] == 3'h0 && data_q[g] == 8'h02)
      |-> ##[26:37] match_w[g])
      else $error("First auto-reload interval out of range.");

    AST_PWM_RISE: assert property (
      (ctrl_q[g][BIT_MD] && step_w[g] && cnt_w[g] == CNT_TOP && data_q[g] != DATA_RST)
      |=> wave_w[g] && cnt_w[g] == CNT_RST)
      else $error("PWM wave not high after wrap.");

    AST_PWM_FALL: assert property (
      (ctrl_q[g][BIT_MD] && step_w[g] && cnt_w[g] != CNT_TOP
       && 8'(cnt_w[g] + 8'h01) == data_q[g])
      |=> !wave_w[g])
      else $error("PWM wave not low at compare.");

    AST_PWM_RUNS: assert property (
      (ctrl_q[g][BIT_MD] && step_w[g])
      |=> cnt_w[g] == 8'($past(cnt_w[g]) + 8'h01))
      else $error("PWM counter did not advance by one.");

    AST_CNT_HOLD: assert property ((!step_w[g] && !clr_q[g]) |=> $stable(cnt_w[g]))
      else $error("Counter moved without a tick.");

    AST_CLR_ZERO: assert property (clr_q[g] |=> cnt_w[g] == CNT_RST)
      else $error("Counter not zero after clear.");

    AST_DATA_KEPT: assert property (!(wr_en && hit_data[g]) |=> $stable(data_q[g]))
      else $error("Data register changed without a write.");

    AST_PIN_PORT: assert property (!ctrl_q[g][BIT_OE] |=> pulse_width_pin[g] == $past(gpio_port_out[g]))
      else $error("Pin not the general port while output disabled.");

    // Bus-side checks: what software reads and writes must agree with the channel state.
    // The answer is registered in the setup cycle, so read data reflect the state one edge earlier.
    AST_READ_DATA: assert property (
      (setup && !pwrite && hit_data[g])
      |=> prdata_q[7:0] == $past(data_q[g]))
      else $error("Data register read returned a stale value.");

    AST_DATA_WRITE: assert property (
      (wr_en && hit_data[g])
      |=> data_q[g] == $past(pwdata[7:0]))
      else $error("Data register write did not land.");

    AST_READ_COUNT: assert property (
      (setup && !pwrite && hit_cnt[g])
      |=> prdata_q[7:0] == $past(cnt_w[g]))
      else $error("Counter read returned a stale value.");

    AST_CLR_PULSE: assert property (
      (wr_en && hit_ctrl[g] && pwdata[BIT_CLR])
      |=> clr_q[g])
      else $error("Clear write gave no clear pulse.");

    AST_CLR_NOT_KEPT: assert property (
      (wr_en && hit_ctrl[g])
      |=> !ctrl_q[g][BIT_CLR])
      else $error("Clear bit was stored in the control register.");

    // Channel-side checks on counting, match and pin routing.
    AST_STOP_NO_STEP: assert property (
      !ctrl_q[g][BIT_EN]
      |-> !step_w[g])
      else $error("Counter stepped while the channel was stopped.");

    AST_STEP_ADVANCES: assert property (
      step_w[g]
      |=> cnt_w[g] == CNT_RST || cnt_w[g] == 8'($past(cnt_w[g]) + 8'h01))
      else $error("Counter step was not plus one or a wrap.");

    AST_AR_WRAP: assert property (
      (!ctrl_q[g][BIT_MD] && step_w[g] && cnt_w[g] == 8'(data_q[g] - 8'h01))
      |=> cnt_w[g] == CNT_RST && match_w[g])
      else $error("Auto-reload counter did not wrap with a match at the last count.");

    AST_PWM_NO_MATCH: assert property (
      ctrl_q[g][BIT_MD]
      |=> !match_w[g])
      else $error("Match raised in PWM mode.");

    AST_IRQ_FROM_MATCH: assert property (
      timer_irq[g]
      |-> $past(match_w[g]))
      else $error("Interrupt request without a match.");

    AST_PWM_WRAP_TOP: assert property (
      (ctrl_q[g][BIT_MD] && step_w[g] && cnt_w[g] == CNT_TOP)
      |=> cnt_w[g] == CNT_RST)
      else $error("PWM counter did not wrap after the top count.");

    AST_PWM_ZERO_LOW: assert property (
      (ctrl_q[g][BIT_MD] && step_w[g] && cnt_w[g] == CNT_TOP && data_q[g] == DATA_RST)
      |=> !wave_w[g])
      else $error("PWM wave high with a zero duty.");

    AST_PIN_WAVE: assert property (
      ctrl_q[g][BIT_OE]
      |=> pulse_width_pin[g] == $past(wave_w[g]))
      else $error("Pin does not follow the wave while output enabled.");
  end
endmodule

// ---- test/pat_timer_tb_top.sv ----
// Self-checking bench for the three-channel 8-bit timer, driven over APB.
// Assumes the shared package, the tick interface and the design modules are compiled first.
`timescale 1ns/1ns
module pat_timer_tb_top;
  import pat_pkg::*;
  logic           mclk;
  logic           rst_n;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [AW-1:0]  paddr;
  logic [DW-1:0]  pwdata;
  logic [DW-1:0]  prdata;
  logic           pready;
  logic           pslverr;
  logic [NCH-1:0] event_input_pin;
  logic [NCH-1:0] gpio_port_out;
  logic [NCH-1:0] pulse_width_pin;
  logic [NCH-1:0] timer_irq;
  logic [DW-1:0]  rd;
  logic           er;
  logic           lv;
  logic [DW-1:0]  base;
  int             fails;
  int             checks;
  int             cyc = 0;
  int             t0;
  int             t1;
  int             hi_n;
  int             lo_n;
  // The slowest divider tap is left out: one interval alone would outrun the cycle budget.
  localparam int DIVS [6] = '{12, 16, 32, 128, 1024, 16384};
  localparam int NS   [6] = '{2, 2, 2, 2, 2, 1};

  pat_timer uut (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .event_input_pin (event_input_pin),
    .gpio_port_out   (gpio_port_out),
    .pulse_width_pin (pulse_width_pin),
    .timer_irq       (timer_irq)
  );

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  function automatic logic [AW-1:0] adr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic [DW-1:0] ctl(input logic en, input logic clr, input logic [2:0] fs,
                                        input logic oe, input logic md);
    return DW'({en, clr, fs, 1'b0, oe, md});
  endfunction

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic hang(input string nm);
    fails++;
    $display("MISMATCH %s expected response seen timeout", nm);
    finish_test();
  endtask

  // The request is held until pready is sampled high; read data is taken at that same edge.
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] wd);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > 16) hang("pready");
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    apb(1'b0, a, '0);
    chk(nm, exp, rd);
    chk("pslverr", '0, DW'(er));
  endtask

  task automatic wait_irq(input int ch, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > lim) hang("timer_irq");
    end while (timer_irq[ch] !== 1'b1);
  endtask

  task automatic wait_pin(input int ch, input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > lim) hang("pulse_width_pin");
    end while (pulse_width_pin[ch] !== lvl);
  endtask

  // Each falling edge is held for a few cycles so the synchronous edge detector sees it.
  task automatic evt_fall(input int ch);
    @(posedge mclk);
    event_input_pin[ch] <= 1'b1;
    repeat (3) @(posedge mclk);
    event_input_pin[ch] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    fails           = 0;
    checks          = 0;
    rst_n           = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = '0;
    pwdata          = '0;
    event_input_pin = '0;
    gpio_port_out   = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("pin_reset", '0, DW'(pulse_width_pin));
    for (int c = 0; c < NCH; c++) begin
      rchk("ctrl_reset", adr(CTRL_IDX[c]), CTRL_RST);
      rchk("count_reset", adr(CNT_IDX[c]), CNT_RST);
      rchk("data_reset", adr(DATA_IDX[c]), DATA_RST);
      apb(1'b1, adr(DATA_IDX[c]), 32'h0000_00A5 + c);
      rchk("data_rw", adr(DATA_IDX[c]), 32'h0000_00A5 + c);
      apb(1'b1, adr(CNT_IDX[c]), 32'h0000_0055);
      rchk("count_ro", adr(CNT_IDX[c]), CNT_RST);
    end
    apb(1'b0, 10'h000, '0);
    chk("unmapped_err", 32'h0000_0001, DW'(er));
    chk("unmapped_data", '0, rd);

    apb(1'b1, adr(DATA_IDX[2]), 32'h0000_0010);
    apb(1'b1, adr(CTRL_IDX[2]), ctl(1'b1, 1'b1, FS_EVENT, 1'b0, 1'b0));
    repeat (2) evt_fall(2);
    apb(1'b0, adr(CNT_IDX[2]), '0);
    base = rd;
    evt_fall(2);
    rchk("event_step", adr(CNT_IDX[2]), base + 1);
    repeat (3) evt_fall(2);
    rchk("event_steps", adr(CNT_IDX[2]), base + 4);
    apb(1'b1, adr(CTRL_IDX[2]), ctl(1'b0, 1'b0, FS_EVENT, 1'b0, 1'b0));
    repeat (2) evt_fall(2);
    rchk("count_hold", adr(CNT_IDX[2]), base + 4);
    apb(1'b1, adr(CTRL_IDX[2]), ctl(1'b0, 1'b1, FS_EVENT, 1'b0, 1'b0));
    rchk("count_clear", adr(CNT_IDX[2]), CNT_RST);
    rchk("clear_reads_zero", adr(CTRL_IDX[2]), ctl(1'b0, 1'b0, FS_EVENT, 1'b0, 1'b0));
    apb(1'b1, adr(CTRL_IDX[2]), 32'h0000_00FF);
    rchk("ctrl_mask", adr(CTRL_IDX[2]), CTRL_RW_MASK);
    apb(1'b1, adr(CTRL_IDX[2]), ctl(1'b0, 1'b1, 3'h0, 1'b0, 1'b0));
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk);
      gpio_port_out[2] <= v[0];
      repeat (3) @(posedge mclk);
      chk("gpio_pass", DW'(v[0]), DW'(pulse_width_pin[2]));
    end

    for (int i = 0; i < 6; i++) begin
      apb(1'b1, adr(DATA_IDX[0]), NS[i]);
      apb(1'b1, adr(CTRL_IDX[0]), ctl(1'b1, 1'b1, 3'(i), 1'b1, 1'b0));
      t0 = cyc;
      wait_irq(0, 40000);
      t1 = cyc;
      lv = pulse_width_pin[0];
      checks++;
      if (t1 - t0 < NS[i] * DIVS[i] || t1 - t0 > (NS[i] + 1) * DIVS[i] + 4) begin
        fails++;
        $display("MISMATCH first_interval expected %0d seen %0d", (NS[i] + 1) * DIVS[i], t1 - t0);
      end
      wait_irq(0, 40000);
      chk("irq_period", NS[i] * DIVS[i], cyc - t1);
      chk("ar_toggle", DW'(!lv), DW'(pulse_width_pin[0]));
      if (i == 3) begin
        wait_irq(0, 1000);
        rchk("count_wrap", adr(CNT_IDX[0]), CNT_RST);
      end
      apb(1'b1, adr(CTRL_IDX[0]), ctl(1'b0, 1'b1, 3'h0, 1'b0, 1'b0));
    end

    apb(1'b1, adr(DATA_IDX[1]), 32'h0000_0040);
    apb(1'b1, adr(CTRL_IDX[1]), ctl(1'b1, 1'b1, 3'h1, 1'b1, 1'b1));
    wait_pin(1, 1'b0, 8000, hi_n);
    wait_pin(1, 1'b1, 8000, hi_n);
    wait_pin(1, 1'b0, 8000, hi_n);
    chk("pwm_high", 64 * 16, hi_n);
    wait_pin(1, 1'b1, 8000, lo_n);
    chk("pwm_low", (256 - 64) * 16, lo_n);
    apb(1'b1, adr(DATA_IDX[1]), 32'h0000_0000);
    wait_pin(1, 1'b0, 8000, lo_n);
    hi_n = 0;
    repeat (4200) begin
      @(posedge mclk);
      if (pulse_width_pin[1] !== 1'b0) hi_n++;
    end
    chk("pwm_zero_high", 0, hi_n);
    finish_test();
  end
endmodule
